/* rtl/sram_defs.svh */
// Constants for the synchronous SRAM sleep and cycle control block
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRAM_ADDR_W 18
`define SRAM_BYTES 4
`define SRAM_BYTE_W 9
`define SRAM_DATA_W (`SRAM_BYTES * `SRAM_BYTE_W)
`define SRAM_BURST_W 2

// Clock period in ns; sleep entry and exit bounds in clock periods, ns and cycles
`define SRAM_CLK_PERIOD_NS 10
`define SRAM_SLEEP_DELAY_PERIODS 2
`define SRAM_SLEEP_DELAY_NS (`SRAM_SLEEP_DELAY_PERIODS * `SRAM_CLK_PERIOD_NS)
`define SRAM_SLEEP_DELAY_CYCLES (`SRAM_SLEEP_DELAY_NS / `SRAM_CLK_PERIOD_NS)

// Burst order pin values
`define SRAM_ORDER_LINEAR 1'h0
`define SRAM_ORDER_INTERLEAVED 1'h1

`endif

/* rtl/sram_pkg.sv */
// Types for the synchronous SRAM sleep and cycle control block
`include "sram_defs.svh"

package sram_pkg;

    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } burst_state_type;

    // Synchronous command pins sampled at each live rising edge outside sleep
    typedef struct packed {
        logic chip_select_n;
        logic chip_select2_n;
        logic chip_select_high;
        logic advance_or_load;
        logic read_write;
        logic [`SRAM_BYTES-1:0] byte_write_n;
        logic [`SRAM_ADDR_W-1:0] address;
    } cmd_type;

    // Write that has its address but waits for or holds its data
    typedef struct packed {
        logic valid;
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_BYTES-1:0] be;
        logic [`SRAM_DATA_W-1:0] data;
    } write_slot_type;

    typedef struct packed {
        logic sync1;
        logic sync2;
        burst_state_type burst;
        logic [`SRAM_ADDR_W-1:0] base_addr;
        logic [`SRAM_BURST_W-1:0] burst_cnt;
        write_slot_type data_phase;
        write_slot_type pending;
        logic [`SRAM_DATA_W-1:0] read_data;
        logic read_data_oe;
    } state_type;

endpackage

/* rtl/sync_sram_sleep_ctrl.sv */
// Sleep handling, cycle decode, burst counting and write forwarding of a flow-through SRAM
//
// Contract
// - In sleep the device acts deselected and performs no read or write.
// - Sleep lasts exactly while the sleep request is high; the code follows the request two rising edges late.
// - In sleep all inputs but the sleep request are ignored; outputs go off.
// - Sleep request is asynchronous and active high.
// - Inputs stop being sampled within two clock periods after the request rises.
// - Sampling resumes within two clock periods after the request falls.
// - Sleep current state reached within two clock periods of the request.
// - Burst order linear when burst order pin is 0, interleaved when 1.
// - Selected only when both low selects are 0 and the high select 1.
// - Reads return newest data, forwarded from the input data register if needed.
// - A stalled clock edge pauses the device and writes nothing.
// - Output enable is ignored during writes; outputs stay off.
// - Address captured only on load edges while selected.
// - Stall keeps burst address and state; bus stays as it was.
// - Counter advances on each continue cycle; type fixed by the begin cycle.
`include "sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_sram_sleep_ctrl #(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int BYTES = `SRAM_BYTES,
    parameter int BYTE_W = `SRAM_BYTE_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sleep_request,
    input wire logic clock_hold_n,
    input wire logic burst_order,
    input wire logic output_enable_n,
    input wire sram_pkg::cmd_type cmd,
    input wire logic [`SRAM_DATA_W-1:0] write_data,
    output logic [`SRAM_DATA_W-1:0] read_data,
    output logic read_data_oe,
    output logic sleep_current
);
    import sram_pkg::*;

    localparam int DATA_W = BYTES * BYTE_W;
    localparam int DEPTH = 1 << ADDR_W;

    if (ADDR_W != `SRAM_ADDR_W || BYTES != `SRAM_BYTES || BYTE_W != `SRAM_BYTE_W) begin : g_bad_params
        $error("Parameters must match the widths of the shared types");
    end

    logic [DATA_W-1:0] mem [DEPTH];
    state_type state_q;
    state_type state_d;
    logic stall;
    logic asleep;
    logic selected;
    logic op_valid;
    logic op_read;
    logic [ADDR_W-1:0] op_addr;
    logic [BYTES-1:0] op_be;
    logic commit;
    logic [DATA_W-1:0] fwd_data;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [`SRAM_BURST_W-1:0] burst_offset(
        input logic order,
        input logic [`SRAM_BURST_W-1:0] start,
        input logic [`SRAM_BURST_W-1:0] cnt
    );
        if (order == `SRAM_ORDER_INTERLEAVED) begin
            return start ^ cnt;
        end
        return start + cnt;
    endfunction

    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_data,
        input logic [DATA_W-1:0] new_data,
        input logic [BYTES-1:0] be
    );
        logic [DATA_W-1:0] res;
        res = old_data;
        for (int i = 0; i < BYTES; i++) begin
            if (be[i]) begin
                res[i*BYTE_W +: BYTE_W] = new_data[i*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    assign asleep = state_q.sync2;
    assign stall = clock_hold_n;
    assign selected = !cmd.chip_select_n && !cmd.chip_select2_n && cmd.chip_select_high;
    // Array writes only on live edges outside sleep
    assign commit = state_q.pending.valid && !stall && !asleep;

    always_comb begin
        op_valid = 1'h0;
        op_read = 1'h0;
        op_addr = cmd.address;
        op_be = ~cmd.byte_write_n;
        if (!asleep && !stall) begin
            if (!cmd.advance_or_load) begin
                op_valid = selected;
                op_read = cmd.read_write;
            end else if (state_q.burst != BURST_IDLE) begin
                op_valid = 1'h1;
                op_read = (state_q.burst == BURST_READ);
                op_addr = {state_q.base_addr[ADDR_W-1:`SRAM_BURST_W],
                           burst_offset(burst_order, state_q.base_addr[`SRAM_BURST_W-1:0],
                                        state_q.burst_cnt + 2'h1)};
            end
        end
    end

    // Newest data for the read address: array, then held write, then arriving data
    always_comb begin
        fwd_data = mem[op_addr];
        if (state_q.pending.valid && state_q.pending.addr == op_addr) begin
            fwd_data = merge(fwd_data, state_q.pending.data, state_q.pending.be);
        end
        if (state_q.data_phase.valid && state_q.data_phase.addr == op_addr) begin
            fwd_data = merge(fwd_data, write_data, state_q.data_phase.be);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.sync1 = sleep_request;
        state_d.sync2 = state_q.sync1;
        if (commit) begin
            state_d.pending.valid = 1'h0;
        end
        if (asleep) begin
            // Deselected; a write still waiting for data is dropped
            state_d.burst = BURST_IDLE;
            state_d.data_phase.valid = 1'h0;
            state_d.read_data_oe = 1'h0;
        end else if (!stall) begin
            if (state_q.data_phase.valid) begin
                state_d.pending.valid = 1'h1;
                state_d.pending.addr = state_q.data_phase.addr;
                state_d.pending.be = state_q.data_phase.be;
                state_d.pending.data = write_data;
            end
            state_d.data_phase.valid = op_valid && !op_read && (op_be != '0);
            state_d.data_phase.addr = op_addr;
            state_d.data_phase.be = op_be;
            case (state_q.burst)
                BURST_IDLE, BURST_READ, BURST_WRITE: begin
                    if (!cmd.advance_or_load) begin
                        if (selected) begin
                            state_d.base_addr = cmd.address;
                            state_d.burst_cnt = '0;
                            state_d.burst = cmd.read_write ? BURST_READ : BURST_WRITE;
                        end else begin
                            state_d.burst = BURST_IDLE;
                        end
                    end else if (state_q.burst != BURST_IDLE) begin
                        state_d.burst_cnt = state_q.burst_cnt + 2'h1;
                    end
                end
                default: begin
                    state_d.burst = BURST_IDLE;
                end
            endcase
            state_d.read_data = op_read ? fwd_data : state_q.read_data;
            state_d.read_data_oe = op_valid && op_read && !output_enable_n;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (commit) begin
            mem[state_q.pending.addr] <= merge(mem[state_q.pending.addr], state_q.pending.data,
                                               state_q.pending.be);
        end
    end

    assign read_data = state_q.read_data;
    assign read_data_oe = state_q.read_data_oe;
    // Same stage as the gating, so pin and gating never disagree
    assign sleep_current = state_q.sync2;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence request_held_high;
        sleep_request [*2];
    endsequence

    sequence request_held_low;
        !sleep_request [*2];
    endsequence

    sequence live_load_selected;
        !srst && !stall && !asleep && !cmd.advance_or_load && selected;
    endsequence

    a_sleep_entry_time: assert property (@(posedge clock) disable iff (srst)
        request_held_high |=> sleep_current && asleep)
        else $error("Sleep not reached two periods after request");

    a_sleep_exit_time: assert property (@(posedge clock) disable iff (srst)
        request_held_low |=> !sleep_current && !asleep)
        else $error("Sampling not resumed two periods after release");

    a_sleep_bus_off: assert property (@(posedge clock) disable iff (srst)
        asleep |=> !read_data_oe && state_q.burst == BURST_IDLE)
        else $error("Bus driven or burst alive in sleep");

    a_sleep_no_write: assert property (@(posedge clock) disable iff (srst)
        asleep |-> !commit)
        else $error("Array written in sleep");

    a_stall_no_write: assert property (@(posedge clock) disable iff (srst)
        stall |-> !commit)
        else $error("Array written on a stalled edge");

    a_stall_hold_state: assert property (@(posedge clock) disable iff (srst)
        stall && !asleep |=> $stable(read_data_oe) && $stable(state_q.burst_cnt) && $stable(state_q.burst))
        else $error("Stall changed burst or bus state");

    a_write_bus_off: assert property (@(posedge clock) disable iff (srst)
        op_valid && !op_read |=> !read_data_oe)
        else $error("Bus driven during write");

    a_load_capture: assert property (@(posedge clock) disable iff (srst)
        live_load_selected |=> state_q.base_addr == $past(cmd.address) && state_q.burst_cnt == '0)
        else $error("Address not captured on load");

    a_deselect_idle: assert property (@(posedge clock) disable iff (srst)
        !stall && !asleep && !cmd.advance_or_load && !selected |=> state_q.burst == BURST_IDLE)
        else $error("Burst alive after deselect");

    a_burst_advance: assert property (@(posedge clock) disable iff (srst)
        !stall && !asleep && cmd.advance_or_load && state_q.burst != BURST_IDLE
        |=> state_q.burst_cnt == $past(state_q.burst_cnt) + 2'h1 && $stable(state_q.burst))
        else $error("Burst counter or type wrong on continue");

endmodule
`default_nettype wire

/* tb/sram_bus_master.sv */
// Bus master model that drives the SRAM command, data and sleep pins
`include "sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sram_bus_master (
    input wire logic clock,
    output logic sleep_request,
    output logic clock_hold_n,
    output logic burst_order,
    output logic output_enable_n,
    output var sram_pkg::cmd_type cmd,
    output logic [`SRAM_DATA_W-1:0] write_data
);
    import sram_pkg::*;

    // Command word from chip selects {cs_n, cs2_n, cs_high}
    function automatic cmd_type mk(input logic [2:0] cs, input logic adv, input logic rw,
                                   input logic [`SRAM_ADDR_W-1:0] a);
        mk = '{cs[2], cs[1], cs[0], adv, rw, 4'h0, a};
    endfunction

    initial begin
        sleep_request = 1'h0;
        clock_hold_n = 1'h0;
        burst_order = 1'h0;
        output_enable_n = 1'h0;
        cmd = mk(3'h6, 1'h0, 1'h1, '0);
        write_data = '0;
    end

    // One bus cycle, launched after the falling edge; idle data toggles
    task automatic cyc(input cmd_type c, input logic dv, input logic [`SRAM_DATA_W-1:0] d, input logic stall);
        @(negedge clock);
        cmd <= c;
        clock_hold_n <= stall;
        write_data <= dv ? d : ~write_data;
    endtask

    task automatic nop();
        cyc(mk(3'h6, 1'h0, 1'h1, '0), 1'h0, '0, 1'h0);
    endtask

    task automatic rd(input logic [`SRAM_ADDR_W-1:0] a);
        cyc(mk(3'h1, 1'h0, 1'h1, a), 1'h0, '0, 1'h0);
    endtask

    task automatic cont();
        cyc(mk(3'h1, 1'h1, 1'h1, '0), 1'h0, '0, 1'h0);
    endtask

    // Address edge, then its data on the next live edge
    task automatic wr_bytes(input logic [`SRAM_ADDR_W-1:0] a, input logic [`SRAM_BYTES-1:0] bw_n,
                            input logic [`SRAM_DATA_W-1:0] d);
        cmd_type c;
        c = mk(3'h1, 1'h0, 1'h0, a);
        c.byte_write_n = bw_n;
        cyc(c, 1'h0, '0, 1'h0);
        cyc(mk(3'h6, 1'h0, 1'h1, '0), 1'h1, d, 1'h0);
    endtask

    task automatic wr(input logic [`SRAM_ADDR_W-1:0] a, input logic [`SRAM_DATA_W-1:0] d);
        wr_bytes(a, 4'h0, d);
    endtask

    // Level pins, changed only just after a falling edge
    task automatic set_pins(input logic order, input logic oe_n);
        burst_order = order;
        output_enable_n = oe_n;
    endtask

    // Drain pending writes before entering sleep
    task automatic set_sleep(input logic v);
        if (v) begin
            nop();
            nop();
        end
        sleep_request = v;
    endtask
endmodule
`default_nettype wire

/* tb/sync_sram_sleep_and_cycle_control_tb.sv */
// Self-checking testbench for the SRAM sleep and cycle control block
`include "sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_sram_sleep_and_cycle_control_tb;
    import sram_pkg::*;

    logic clock;
    logic srst;
    logic sleep_request;
    logic clock_hold_n;
    logic burst_order;
    logic output_enable_n;
    cmd_type cmd;
    logic [`SRAM_DATA_W-1:0] write_data;
    logic [`SRAM_DATA_W-1:0] read_data;
    logic read_data_oe;
    logic sleep_current;
    int n_errors = 0;
    int samples_checked = 0;

    sram_bus_master u_master (.clock(clock), .sleep_request(sleep_request), .clock_hold_n(clock_hold_n),
        .burst_order(burst_order), .output_enable_n(output_enable_n), .cmd(cmd), .write_data(write_data));

    sync_sram_sleep_ctrl u_dut (.clock(clock), .srst(srst), .sleep_request(sleep_request),
        .clock_hold_n(clock_hold_n), .burst_order(burst_order), .output_enable_n(output_enable_n),
        .cmd(cmd), .write_data(write_data), .read_data(read_data), .read_data_oe(read_data_oe),
        .sleep_current(sleep_current));

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    function automatic logic [`SRAM_DATA_W-1:0] pat(input logic [`SRAM_ADDR_W-1:0] a);
        return {a, ~a};
    endfunction

    function automatic logic [1:0] boff(input logic o, input logic [1:0] s, input int n);
        return o ? (s ^ n[1:0]) : (s + n[1:0]);
    endfunction

    task automatic chk_data(input logic [`SRAM_DATA_W-1:0] exp);
        samples_checked++;
        if (read_data !== exp) begin
            n_errors++;
            $display("BAD %0t read data %h expected %h", $time, read_data, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic t_forward();
        u_master.cyc(u_master.mk(3'h1, 1'h0, 1'h0, 18'h10), 1'h0, '0, 1'h0);
        u_master.cyc(u_master.mk(3'h1, 1'h0, 1'h1, 18'h10), 1'h1, pat(18'h10), 1'h0);
        u_master.nop();
        chk_data(pat(18'h10));
        chk_bit(read_data_oe, 1'h1, "oe");
        u_master.rd(18'h10);
        u_master.nop();
        chk_data(pat(18'h10));
        $display("test forward done");
    endtask

    task automatic t_select();
        for (int i = 0; i < 8; i++) begin
            u_master.cyc(u_master.mk(i[2:0], 1'h0, 1'h1, 18'h10), 1'h0, '0, 1'h0);
            u_master.nop();
            chk_bit(read_data_oe, i == 1, "oe");
        end
        $display("test select done");
    endtask

    task automatic t_burst();
        for (int a = 0; a < 4; a++) begin
            u_master.wr(18'h40 + a[1:0], pat(18'h40 + a[1:0]));
        end
        for (int k = 0; k < 8; k++) begin
            u_master.set_pins(k[2], 1'h0);
            u_master.rd(18'h40 + k[1:0]);
            for (int n = 1; n < 4; n++) begin
                u_master.cont();
                chk_data(pat(18'h40 + boff(k[2], k[1:0], n - 1)));
            end
            u_master.nop();
            chk_data(pat(18'h40 + boff(k[2], k[1:0], 3)));
        end
        $display("test burst done");
    endtask

    task automatic t_stall();
        u_master.cyc(u_master.mk(3'h1, 1'h0, 1'h0, 18'h20), 1'h0, '0, 1'h0);
        u_master.cyc(u_master.mk(3'h6, 1'h0, 1'h1, 18'h0), 1'h1, 36'h0, 1'h1);
        u_master.cyc(u_master.mk(3'h6, 1'h0, 1'h1, 18'h0), 1'h1, pat(18'h20), 1'h0);
        u_master.rd(18'h20);
        u_master.cyc(u_master.mk(3'h1, 1'h1, 1'h1, 18'h0), 1'h0, '0, 1'h1);
        chk_data(pat(18'h20));
        u_master.nop();
        chk_data(pat(18'h20));
        chk_bit(read_data_oe, 1'h1, "oe");
        u_master.rd(18'h20);
        u_master.wr(18'h30, pat(18'h30));
        chk_bit(read_data_oe, 1'h0, "oe");
        $display("test stall done");
    endtask

    task automatic t_bytes();
        logic [`SRAM_DATA_W-1:0] exp;
        exp = pat(18'h50);
        exp[8:0] = 9'h1FF;
        u_master.set_pins(1'h0, 1'h0);
        u_master.wr(18'h50, pat(18'h50));
        u_master.wr_bytes(18'h50, 4'hE, 36'hF_FFFF_FFFF);
        u_master.rd(18'h50);
        u_master.nop();
        chk_data(exp);
        u_master.wr_bytes(18'h50, 4'hF, 36'h0);
        u_master.set_pins(1'h0, 1'h1);
        u_master.rd(18'h50);
        u_master.nop();
        chk_bit(read_data_oe, 1'h0, "oe");
        u_master.set_pins(1'h0, 1'h0);
        u_master.rd(18'h50);
        u_master.nop();
        chk_data(exp);
        u_master.cyc(u_master.mk(3'h1, 1'h0, 1'h0, 18'h60), 1'h0, '0, 1'h0);
        for (int n = 0; n < 4; n++) begin
            u_master.cyc(u_master.mk(n < 3 ? 3'h1 : 3'h6, n < 3, 1'h1, '0), 1'h1, pat(18'h60 + n[1:0]), 1'h0);
        end
        u_master.rd(18'h60);
        for (int n = 0; n < 4; n++) begin
            u_master.cont();
            chk_data(pat(18'h60 + n[1:0]));
        end
        $display("test bytes done");
    endtask

    task automatic t_sleep();
        u_master.set_sleep(1'h1);
        u_master.nop();
        u_master.nop();
        chk_bit(sleep_current, 1'h1, "sleep");
        u_master.wr(18'h30, 36'h0);
        u_master.rd(18'h30);
        u_master.nop();
        chk_bit(read_data_oe, 1'h0, "oe");
        u_master.set_sleep(1'h0);
        u_master.nop();
        u_master.nop();
        chk_bit(sleep_current, 1'h0, "sleep");
        u_master.rd(18'h30);
        u_master.nop();
        chk_data(pat(18'h30));
        $display("test sleep done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_errors++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        srst = 1'h1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        srst = 1'h0;
        chk_bit(read_data_oe, 1'h0, "oe");
        chk_bit(sleep_current, 1'h0, "sleep");
        t_forward();
        t_select();
        t_burst();
        t_stall();
        t_bytes();
        t_sleep();
        tally_and_finish();
    end
endmodule
`default_nettype wire
